// ### design/dsc_pkg.sv
// Purpose: Constants for the decoder status and configuration registers
// Assumes: 8-bit register port, one clock at 40 MHz
// Notes:   Offsets, fields and the config, subcode address, preview and host select reset values
package dsc_pkg;

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] OFF_MODE_STATUS  = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h01;
  localparam logic [7:0] OFF_SOFT_RESET   = 8'h02;
  localparam logic [7:0] OFF_SUB_ADDR_LO  = 8'h03;
  localparam logic [7:0] OFF_SUB_ADDR_HI  = 8'h04;
  localparam logic [7:0] OFF_INPUT_CONFIG = 8'h05;
  localparam logic [7:0] OFF_EVENT_STATUS = 8'h06;
  localparam logic [7:0] OFF_EVENT_CLEAR  = 8'h07;
  localparam logic [7:0] OFF_EVENT_ENABLE = 8'h08;
  localparam logic [7:0] OFF_HOST_STATE   = 8'h09;

  // ------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------
  localparam int unsigned PREVIEW_LSB    = 4;
  localparam int unsigned INVALID_BIT    = 7;
  localparam int unsigned ECC_DONE_BIT   = 5;
  localparam int unsigned HSEL_W         = 3;
  localparam int unsigned SUB_ADDR_W     = 10;
  localparam int unsigned SUB_HI_W       = 2;
  localparam int unsigned CFG_FORMAT_BIT = 7;
  localparam int unsigned CFG_OVS_HI_BIT = 6;
  localparam int unsigned CFG_OVS_LO_BIT = 5;
  localparam int unsigned CFG_QW_FMT_BIT = 4;
  localparam int unsigned CFG_QW_ON_BIT  = 3;
  localparam int unsigned CFG_QW_RAW_BIT = 2;
  localparam int unsigned CFG_RAM_TST_BIT = 1;
  localparam logic [7:0]  CFG_USED_MASK  = 8'hFE;

  localparam int unsigned EV_W       = 3;
  localparam int unsigned EV_DECODER = 0;
  localparam int unsigned EV_ECC     = 1;
  localparam int unsigned EV_INVALID = 2;

  // ------------------------------------------------------------
  // Codes and reset values
  // ------------------------------------------------------------
  localparam logic [2:0] HSEL_COMPAT1  = 3'h0;
  localparam logic [2:0] HSEL_ATAPI    = 3'h1;
  localparam logic [2:0] HSEL_COMPAT2  = 3'h2;
  localparam logic [2:0] HSEL_UNKNOWN  = 3'h3;
  localparam logic [2:0] HSEL_HW_RESET = 3'h7;

  localparam logic [1:0] OVS_NONE  = 2'h0;
  localparam logic [1:0] OVS_TWO   = 2'h1;
  localparam logic [1:0] OVS_FOUR  = 2'h2;
  localparam logic [1:0] TICK_ONE  = 2'h0;
  localparam logic [1:0] TICK_TWO  = 2'h1;
  localparam logic [1:0] TICK_FOUR = 2'h3;

  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [9:0] SUB_RESET     = 10'h000;
  localparam logic [3:0] PREVIEW_RESET = 4'h0;

  typedef enum logic [2:0] {
    DSC_HOST_WAIT,
    DSC_HOST_COMPAT1,
    DSC_HOST_ATAPI,
    DSC_HOST_COMPAT2,
    DSC_HOST_UNKNOWN,
    DSC_HOST_RESERVED
  } dsc_host_type;

endpackage

// ### design/dsc_sync2.sv
// Purpose: Two-stage synchroniser for levels from pins
// Assumes: Inputs are asynchronous to clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module dsc_sync2 #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage1   <= INIT;
      sync_out <= INIT;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ### design/dsc_regs.sv
// How it works
// [R1] Status reg 2 bits 7..4 preview next mode byte, each ORed with erasure.
// [R2] Top preview bit clear gives mode 0..7; set means above seven or error.
// [R3] Sub-CPU read of status register 3 clears pending decoder interrupt.
// [R4] Status 3 bit 7 is 0 while decoder registers valid, 1 when invalid.
// [R5] Status 3 bit 5 set once ECC ran on current block, else 0.
// [R6] Any write to reset register reinitialises all registers, sets host mode.
// [R7] Host select: 0 compat one, 1 ATAPI, 2 compat two, 3 unknown host.
// [R8] Hardware reset sets host select to 111 and waits for a reset write.
// [R9] After hardware reset host pins float unless host read strobe is low.
// [R10] Ten-bit subcode block address in low and high registers, first 1 kbyte.
// [R11] Config bit 7 selects serial format: 0 standard, 1 Japanese standard.
// [R12] Config bits 6..5 select oversampling: none, two times, four times.
// [R13] Serial bit clock times subcode recovery, scaled by oversampling factor.
// [R14] Config bit 4 selects subcode input format: 0 V4, 1 Japanese standard.
// [R15] Config bit 3 switches the subcode interface on.
// [R16] Config bit 2 selects cooked (0) or raw (1) subcode data.
// [R17] Config bit 1 puts external buffer RAM into test mode.
// [R18] Reserved bits read zero, writes ignored; reserved host codes avoided.
//
// Purpose: Decoder status, soft reset, subcode address and input config
// Assumes: Decoder pulses are one cycle on clock; pins are asynchronous
// Notes:   Read data valid in the cycle after the read strobe only
`timescale 1ns/10ps
module dsc_regs (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] mode_byte,
  input  wire logic       mode_byte_valid,
  input  wire logic       erasure_flag,
  input  wire logic       decoder_irq_event,
  input  wire logic       decoder_regs_update,
  input  wire logic       block_start,
  input  wire logic       ecc_done_event,
  input  wire logic       host_read_strobe_n,
  input  wire logic       serial_bit_clock,
  output logic            decoder_irq,
  output logic            irq,
  output logic            soft_reset,
  output logic      [2:0] host_select,
  output logic            host_wait,
  output logic            host_pins_oe,
  output logic      [9:0] subcode_block_address,
  output logic            serial_format_sel,
  output logic            oversample_hi,
  output logic            oversample_lo,
  output logic            subcode_format_sel,
  output logic            subcode_if_enable,
  output logic            subcode_raw_sel,
  output logic            buffer_test_mode,
  output logic            subcode_bit_tick
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  dsc_pkg::dsc_host_type host_state;
  dsc_pkg::dsc_host_type next_host_state;

  logic [3:0]            next_mode_preview;
  logic [3:0]            next_preview;
  logic                  regs_invalid_flag;
  logic                  ecc_done_flag;
  logic [7:0]            input_path_config;
  logic [dsc_pkg::EV_W-1:0] event_status;
  logic [dsc_pkg::EV_W-1:0] event_enable;
  logic [dsc_pkg::EV_W-1:0] event_pulse;
  logic [7:0]            next_rdata;
  logic [7:0]            decoder_irq_status;
  logic                  wr_soft_reset;
  logic                  rd_irq_status;
  logic                  wr_sub_lo;
  logic                  wr_sub_hi;
  logic                  wr_config;
  logic                  wr_ev_clear;
  logic                  wr_ev_enable;
  logic [1:0]            pin_sync;
  logic                  read_strobe_low;
  logic                  sbc_sync;
  logic                  sbc_last;
  logic                  sbc_rise;
  logic [1:0]            tick_count;
  logic [1:0]            tick_limit;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  dsc_sync2 #(
    .WIDTH (2),
    .INIT  (2'h1)
  ) u_pin_sync (
    .clock    (clock),
    .resetn   (resetn),
    .async_in ({serial_bit_clock, host_read_strobe_n}),
    .sync_out (pin_sync)
  );

  assign read_strobe_low = ~pin_sync[0];
  assign sbc_sync        = pin_sync[1];

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  always_comb begin
    wr_soft_reset = 1'b0;
    rd_irq_status = 1'b0;
    wr_sub_lo     = 1'b0;
    wr_sub_hi     = 1'b0;
    wr_config     = 1'b0;
    wr_ev_clear   = 1'b0;
    wr_ev_enable  = 1'b0;
    if (reg_write && reg_addr == dsc_pkg::OFF_SOFT_RESET) begin
      wr_soft_reset = 1'b1;
    end else if (reg_write && reg_addr == dsc_pkg::OFF_SUB_ADDR_LO) begin
      wr_sub_lo = 1'b1;
    end else if (reg_write && reg_addr == dsc_pkg::OFF_SUB_ADDR_HI) begin
      wr_sub_hi = 1'b1;
    end else if (reg_write && reg_addr == dsc_pkg::OFF_INPUT_CONFIG) begin
      wr_config = 1'b1;
    end else if (reg_write && reg_addr == dsc_pkg::OFF_EVENT_CLEAR) begin
      wr_ev_clear = 1'b1;
    end else if (reg_write && reg_addr == dsc_pkg::OFF_EVENT_ENABLE) begin
      wr_ev_enable = 1'b1;
    end else if (reg_read && reg_addr == dsc_pkg::OFF_IRQ_STATUS) begin
      rd_irq_status = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Mode byte preview
  // ------------------------------------------------------------
  always_comb begin
    next_preview[3]   = |mode_byte[7:3] | erasure_flag;      // [R1] [R2]
    next_preview[2:0] = mode_byte[2:0] | {3{erasure_flag}};  // [R1] [R2]
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      next_mode_preview <= dsc_pkg::PREVIEW_RESET;
    end else if (wr_soft_reset) begin
      next_mode_preview <= dsc_pkg::PREVIEW_RESET;          // [R6]
    end else if (mode_byte_valid) begin
      next_mode_preview <= next_preview;                    // [R1]
    end
  end

  // ------------------------------------------------------------
  // Decoder interrupt and status register 3
  // ------------------------------------------------------------
  // New event in the read cycle survives the read
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      decoder_irq <= 1'b0;
    end else if (wr_soft_reset) begin
      decoder_irq <= 1'b0;                                  // [R6]
    end else if (decoder_irq_event) begin
      decoder_irq <= 1'b1;
    end else if (rd_irq_status) begin
      decoder_irq <= 1'b0;                                  // [R3]
    end
  end

  // Invalid until the first decoder interrupt delivers a block
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regs_invalid_flag <= 1'b1;
    end else if (wr_soft_reset) begin
      regs_invalid_flag <= 1'b1;                            // [R6]
    end else if (decoder_irq_event) begin
      regs_invalid_flag <= 1'b0;                            // [R4]
    end else if (decoder_regs_update) begin
      regs_invalid_flag <= 1'b1;                            // [R4]
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ecc_done_flag <= 1'b0;
    end else if (wr_soft_reset) begin
      ecc_done_flag <= 1'b0;                                // [R6]
    end else if (ecc_done_event) begin
      ecc_done_flag <= 1'b1;                                // [R5]
    end else if (block_start) begin
      ecc_done_flag <= 1'b0;                                // [R5]
    end
  end

  always_comb begin
    decoder_irq_status = 8'h00;                             // [R18]
    decoder_irq_status[dsc_pkg::INVALID_BIT]  = regs_invalid_flag; // [R4]
    decoder_irq_status[dsc_pkg::ECC_DONE_BIT] = ecc_done_flag;     // [R5]
  end

  // ------------------------------------------------------------
  // Soft reset and host mode
  // ------------------------------------------------------------
  always_comb begin
    case (reg_wdata[dsc_pkg::HSEL_W-1:0])                  // [R7]
      dsc_pkg::HSEL_COMPAT1: next_host_state = dsc_pkg::DSC_HOST_COMPAT1;
      dsc_pkg::HSEL_ATAPI:   next_host_state = dsc_pkg::DSC_HOST_ATAPI;
      dsc_pkg::HSEL_COMPAT2: next_host_state = dsc_pkg::DSC_HOST_COMPAT2;
      dsc_pkg::HSEL_UNKNOWN: next_host_state = dsc_pkg::DSC_HOST_UNKNOWN;
      default:               next_host_state = dsc_pkg::DSC_HOST_RESERVED;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      host_state  <= dsc_pkg::DSC_HOST_WAIT;                // [R8]
      host_select <= dsc_pkg::HSEL_HW_RESET;                // [R8]
    end else if (wr_soft_reset) begin
      host_state  <= next_host_state;                       // [R6]
      host_select <= reg_wdata[dsc_pkg::HSEL_W-1:0];        // [R6]
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= wr_soft_reset;                          // [R6]
    end
  end

  // Reserved codes float the host bus like an unknown host
  always_comb begin
    case (host_state)
      dsc_pkg::DSC_HOST_WAIT:    host_pins_oe = read_strobe_low; // [R9]
      dsc_pkg::DSC_HOST_COMPAT1: host_pins_oe = 1'b1;       // [R7]
      dsc_pkg::DSC_HOST_ATAPI:   host_pins_oe = 1'b1;       // [R7]
      dsc_pkg::DSC_HOST_COMPAT2: host_pins_oe = 1'b1;       // [R7]
      default:                   host_pins_oe = 1'b0;       // [R7] [R18]
    endcase
  end

  assign host_wait = (host_state == dsc_pkg::DSC_HOST_WAIT); // [R8]

  // ------------------------------------------------------------
  // Subcode address and input configuration
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      subcode_block_address <= dsc_pkg::SUB_RESET;
    end else if (wr_soft_reset) begin
      subcode_block_address <= dsc_pkg::SUB_RESET;          // [R6]
    end else if (wr_sub_lo) begin
      subcode_block_address[7:0] <= reg_wdata;              // [R10]
    end else if (wr_sub_hi) begin
      subcode_block_address[9:8] <=
        reg_wdata[dsc_pkg::SUB_HI_W-1:0];                   // [R10] [R18]
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      input_path_config <= dsc_pkg::CFG_RESET;
    end else if (wr_soft_reset) begin
      input_path_config <= dsc_pkg::CFG_RESET;              // [R6]
    end else if (wr_config) begin
      input_path_config <= reg_wdata & dsc_pkg::CFG_USED_MASK; // [R18]
    end
  end

  assign serial_format_sel  = input_path_config[dsc_pkg::CFG_FORMAT_BIT];  // [R11]
  assign oversample_hi      = input_path_config[dsc_pkg::CFG_OVS_HI_BIT];  // [R12]
  assign oversample_lo      = input_path_config[dsc_pkg::CFG_OVS_LO_BIT];  // [R12]
  assign subcode_format_sel = input_path_config[dsc_pkg::CFG_QW_FMT_BIT];  // [R14]
  assign subcode_if_enable  = input_path_config[dsc_pkg::CFG_QW_ON_BIT];   // [R15]
  assign subcode_raw_sel    = input_path_config[dsc_pkg::CFG_QW_RAW_BIT];  // [R16]
  assign buffer_test_mode   = input_path_config[dsc_pkg::CFG_RAM_TST_BIT]; // [R17]

  // ------------------------------------------------------------
  // Subcode timing from the serial bit clock
  // ------------------------------------------------------------
  // Code 11 is undefined; treated as no oversampling
  always_comb begin
    case ({oversample_hi, oversample_lo})
      dsc_pkg::OVS_TWO:  tick_limit = dsc_pkg::TICK_TWO;    // [R12] [R13]
      dsc_pkg::OVS_FOUR: tick_limit = dsc_pkg::TICK_FOUR;   // [R12] [R13]
      default:           tick_limit = dsc_pkg::TICK_ONE;    // [R12] [R13]
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sbc_last <= 1'b1;
    end else begin
      sbc_last <= sbc_sync;
    end
  end

  assign sbc_rise = sbc_sync & ~sbc_last;                   // [R13]

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_count       <= 2'h0;
      subcode_bit_tick <= 1'b0;
    end else if (!subcode_if_enable || wr_soft_reset) begin
      tick_count       <= 2'h0;                             // [R15]
      subcode_bit_tick <= 1'b0;
    end else if (sbc_rise && tick_count >= tick_limit) begin
      tick_count       <= 2'h0;
      subcode_bit_tick <= 1'b1;                             // [R13]
    end else if (sbc_rise) begin
      tick_count       <= tick_count + 2'h1;
      subcode_bit_tick <= 1'b0;
    end else begin
      subcode_bit_tick <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Event status, enable and interrupt
  // ------------------------------------------------------------
  assign event_pulse[dsc_pkg::EV_DECODER] = decoder_irq_event;
  assign event_pulse[dsc_pkg::EV_ECC]     = ecc_done_event;
  assign event_pulse[dsc_pkg::EV_INVALID] = decoder_regs_update;

  // Set beats a clear in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      event_status <= '0;
    end else if (wr_soft_reset) begin
      event_status <= '0;                                   // [R6]
    end else if (wr_ev_clear) begin
      event_status <= (event_status &
        ~reg_wdata[dsc_pkg::EV_W-1:0]) | event_pulse;
    end else begin
      event_status <= event_status | event_pulse;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      event_enable <= '0;
    end else if (wr_soft_reset) begin
      event_enable <= '0;                                   // [R6]
    end else if (wr_ev_enable) begin
      event_enable <= reg_wdata[dsc_pkg::EV_W-1:0];
    end
  end

  assign irq = |(event_status & event_enable);

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (!reg_read) begin
      next_rdata = 8'h00;
    end else if (reg_addr == dsc_pkg::OFF_MODE_STATUS) begin
      next_rdata[7:dsc_pkg::PREVIEW_LSB] = next_mode_preview; // [R1]
    end else if (reg_addr == dsc_pkg::OFF_IRQ_STATUS) begin
      next_rdata = decoder_irq_status;                      // [R4] [R5]
    end else if (reg_addr == dsc_pkg::OFF_SUB_ADDR_LO) begin
      next_rdata = subcode_block_address[7:0];              // [R10]
    end else if (reg_addr == dsc_pkg::OFF_SUB_ADDR_HI) begin
      next_rdata[dsc_pkg::SUB_HI_W-1:0] =
        subcode_block_address[9:8];                         // [R10] [R18]
    end else if (reg_addr == dsc_pkg::OFF_INPUT_CONFIG) begin
      next_rdata = input_path_config;
    end else if (reg_addr == dsc_pkg::OFF_EVENT_STATUS) begin
      next_rdata[dsc_pkg::EV_W-1:0] = event_status;
    end else if (reg_addr == dsc_pkg::OFF_EVENT_ENABLE) begin
      next_rdata[dsc_pkg::EV_W-1:0] = event_enable;
    end else if (reg_addr == dsc_pkg::OFF_HOST_STATE) begin
      next_rdata[dsc_pkg::HSEL_W-1:0] = host_select;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ### test/dsc_regs_props.sv
// Purpose: Port checks for the decoder status and config registers
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound onto every dsc_regs instance
`timescale 1ns/10ps
module dsc_regs_props (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       decoder_irq_event,
  input wire logic       host_read_strobe_n,
  input wire logic       decoder_irq,
  input wire logic       soft_reset,
  input wire logic [2:0] host_select,
  input wire logic       host_wait,
  input wire logic       host_pins_oe,
  input wire logic [9:0] subcode_block_address
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  rd_clear_a: assert property (
    reg_read && reg_addr == 8'h01 && !decoder_irq_event |=> !decoder_irq)
    else $error("decoder irq survived a status read");
  irq_set_a: assert property (
    decoder_irq_event && !reg_write |=> decoder_irq)
    else $error("decoder irq not raised by event");
  hsel_load_a: assert property (
    reg_write && reg_addr == 8'h02
    |=> soft_reset && host_select == $past(reg_wdata[2:0]))
    else $error("reset register write not applied");
  soft_clear_a: assert property (
    reg_write && reg_addr == 8'h02 |=> subcode_block_address == 10'h000)
    else $error("soft reset left subcode address");
  sub_lo_a: assert property (
    reg_write && reg_addr == 8'h03
    |=> subcode_block_address[7:0] == $past(reg_wdata))
    else $error("subcode address low byte not loaded");
  oe_float_a: assert property (
    host_wait && host_read_strobe_n [*4] |-> !host_pins_oe)
    else $error("host pins driven while waiting");
  oe_drive_a: assert property (
    host_wait && !host_read_strobe_n [*4] |-> host_pins_oe)
    else $error("host pins not driven on low read strobe");
  rdata_idle_a: assert property (
    !$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  hw_wait_a: assert property (
    $rose(resetn) |-> host_select == 3'h7 && host_wait)
    else $error("host select not 111 after reset");
endmodule

bind dsc_regs dsc_regs_props i_dsc_regs_props (
  .clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .decoder_irq_event, .host_read_strobe_n, .decoder_irq,
  .soft_reset, .host_select, .host_wait, .host_pins_oe,
  .subcode_block_address
);

// ### test/dsc_cpu.sv
// Purpose: Sub-CPU side of the register port
// Assumes: Strobes one cycle long, data the cycle after a read
// Notes:   Tasks return one step after the taking edge
`timescale 1ns/10ps
module dsc_cpu (
  input  wire logic       clock,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_write,
  output logic            reg_read,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // Stale data must not look valid
    reg_wdata <= ~v;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
endmodule

// ### test/test_decoder_status_config_regs.sv
// Purpose: Self-checking bench for the decoder status registers
// Assumes: 40 MHz clock, sub-CPU model on the register port
// Notes:   Tick test drives the serial bit clock
`timescale 1ns/10ps
module test_decoder_status_config_regs;
  logic       clock, resetn, er, hs_n, sbc, tick, reg_write, reg_read;
  logic       decoder_irq, irq, soft_reset, host_wait, host_pins_oe;
  logic [7:0] mb, d, reg_addr, reg_wdata, reg_rdata;
  logic [4:0] ev;
  logic [2:0] host_select;
  logic [9:0] sub_addr;
  logic [7:1] cfg;
  int         bad_count, n_tests;

  dsc_cpu i_dsc_cpu (.clock, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata);
  dsc_regs i_dsc_regs (.clock, .resetn, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .mode_byte(mb),
    .mode_byte_valid(ev[4]), .erasure_flag(er),
    .decoder_irq_event(ev[0]), .decoder_regs_update(ev[1]),
    .block_start(ev[2]), .ecc_done_event(ev[3]),
    .host_read_strobe_n(hs_n), .serial_bit_clock(sbc), .decoder_irq,
    .irq, .soft_reset, .host_select, .host_wait, .host_pins_oe,
    .subcode_block_address(sub_addr), .serial_format_sel(cfg[7]),
    .oversample_hi(cfg[6]), .oversample_lo(cfg[5]),
    .subcode_format_sel(cfg[4]), .subcode_if_enable(cfg[3]),
    .subcode_raw_sel(cfg[2]), .buffer_test_mode(cfg[1]),
    .subcode_bit_tick(tick));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input string n, input logic [9:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    ev <= 5'h01 << k;
    @(posedge clock);
    ev <= 5'h00;
    #1;
  endtask
  task automatic hs(input logic v);
    @(posedge clock);
    hs_n <= v;
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic t_reset;
    chk("host select", 10'h007, 10'(host_select));
    chk("host wait", 10'h001, 10'(host_wait));
    chk("pins idle", 10'h000, 10'(host_pins_oe));
    hs(1'b0);
    chk("pins on strobe", 10'h001, 10'(host_pins_oe));
    hs(1'b1);
    chk("pins released", 10'h000, 10'(host_pins_oe));
    i_dsc_cpu.rd(8'h02, d);
    chk("write-only read", 10'h000, 10'(d));
    i_dsc_cpu.rd(8'h0A, d);
    chk("unmapped read", 10'h000, 10'(d));
    $display("test reset done");
  endtask
  task automatic t_preview;
    logic [8:0] pv [4] = '{9'h001, 9'h007, 9'h008, 9'h105};
    logic [7:0] pe [4] = '{8'h10, 8'h70, 8'h80, 8'hF0};
    foreach (pv[i]) begin
      @(posedge clock);
      mb <= pv[i][7:0];
      er <= pv[i][8];
      pulse(4);
      i_dsc_cpu.rd(8'h00, d);
      chk("preview", 10'(pe[i]), 10'(d));
    end
    $display("test preview done");
  endtask
  task automatic t_status;
    pulse(0);
    chk("irq pending", 10'h001, 10'(decoder_irq));
    i_dsc_cpu.rd(8'h01, d);
    chk("status valid", 10'h000, 10'(d));
    chk("irq cleared", 10'h000, 10'(decoder_irq));
    pulse(3);
    i_dsc_cpu.rd(8'h01, d);
    chk("status ecc", 10'h020, 10'(d));
    pulse(1);
    i_dsc_cpu.rd(8'h01, d);
    chk("status invalid", 10'h0A0, 10'(d));
    pulse(2);
    i_dsc_cpu.rd(8'h01, d);
    chk("status new block", 10'h080, 10'(d));
    i_dsc_cpu.rd(8'h06, d);
    chk("events", 10'h007, 10'(d));
    chk("irq masked", 10'h000, 10'(irq));
    i_dsc_cpu.wr(8'h08, 8'h02);
    chk("irq enabled", 10'h001, 10'(irq));
    i_dsc_cpu.wr(8'h07, 8'h02);
    chk("irq cleared", 10'h000, 10'(irq));
    $display("test status done");
  endtask
  task automatic t_config;
    for (int b = 1; b < 8; b++) begin
      i_dsc_cpu.wr(8'h05, 8'h01 << b);
      chk("cfg pins", 10'(8'h01 << b), 10'({cfg, 1'b0}));
      i_dsc_cpu.rd(8'h05, d);
      chk("cfg read", 10'(8'h01 << b), 10'(d));
    end
    i_dsc_cpu.wr(8'h05, 8'hFF);
    i_dsc_cpu.rd(8'h05, d);
    chk("cfg reserved", 10'h0FE, 10'(d));
    $display("test config done");
  endtask
  task automatic t_subaddr;
    i_dsc_cpu.wr(8'h03, 8'hFF);
    i_dsc_cpu.wr(8'h04, 8'hFF);
    chk("sub addr", 10'h3FF, sub_addr);
    i_dsc_cpu.rd(8'h04, d);
    chk("sub addr hi", 10'h003, 10'(d));
    i_dsc_cpu.wr(8'h03, 8'h5A);
    chk("sub addr lo", 10'h35A, sub_addr);
    $display("test subaddr done");
  endtask
  task automatic t_host;
    hs(1'b0);
    for (int c = 0; c < 4; c++) begin
      i_dsc_cpu.wr(8'h03, 8'hAA);
      i_dsc_cpu.wr(8'h02, 8'hF8 | 8'(c));
      chk("soft pulse", 10'h001, 10'(soft_reset));
      chk("host code", 10'(c), 10'(host_select));
      chk("addr init", 10'h000, sub_addr);
      chk("cfg init", 10'h000, 10'({cfg, 1'b0}));
      chk("wait over", 10'h000, 10'(host_wait));
      chk("host pins", 10'(c < 3), 10'(host_pins_oe));
      i_dsc_cpu.rd(8'h01, d);
      chk("status init", 10'h080, 10'(d));
    end
    hs(1'b1);
    $display("test host done");
  endtask
  task automatic t_tick;
    for (int m = 0; m < 3; m++) begin
      int n = 0;
      i_dsc_cpu.wr(8'h05, 8'h08 | 8'(m << 5));
      for (int k = 0; k < 68; k++) begin
        @(posedge clock);
        sbc <= k[2];
        #1 n += tick;
      end
      chk("ticks", 10'(8 >> m), 10'(n));
    end
    $display("test tick done");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clock);
    bad_count++;
    print_verdict;
  end

  initial begin
    resetn = 1'b0;
    ev = 5'h00;
    mb = 8'h00;
    er = 1'b0;
    hs_n = 1'b1;
    sbc = 1'b0;
    bad_count = 0;
    n_tests = 0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    t_reset;
    t_preview;
    t_status;
    t_config;
    t_subaddr;
    t_host;
    t_tick;
    print_verdict;
  end
endmodule
